// ==== rif_irq_flags.sv ====
// Purpose: event flags, enables, second irq output, battery monitor
// Assumes: events and register writes come from same-clock logic
// Notes:   battery rail is a 12-bit millivolt code from an asynchronous adc
`timescale 1ns/1ps
`include "rif_consts.svh"
module rif_irq_flags
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // register access
  input  wire rif_pkg::rif_wr_s   regWr,
  input  wire logic [9:0]         rdAddr,
  output logic [7:0]              rdData_r,
  // event sources
  input  wire rif_pkg::rif_sys_ev_s sysEv,
  input  wire rif_pkg::rif_pkt_ev_s pktEv,
  input  wire logic               ccaResultValid,
  input  wire logic [11:0]        batterySupplyRail,
  // outputs, and the cca result input
  output logic                    irqOut1_r,
  output logic                    irqOut2_r,
  output logic                    ccaResult_r,
  input  wire logic               ccaResultIn
);
  import rif_pkg::*;

  logic [7:0]  sysEn1_r;
  logic [7:0]  pktEn1_r;
  logic [7:0]  sysEn2_r;
  logic [7:0]  pktEn2_r;
  logic [7:0]  sysFlags_r;
  logic [7:0]  pktFlags_r;
  logic [7:0]  battTrip_r;
  logic [11:0] railSync1_r;
  logic [11:0] railSync2_r;
  logic        battLow_r;
  logic        battLowPrev_r;
  logic        ccaPending_r;
  logic [7:0]  sysSet;
  logic [7:0]  pktSet;
  logic [11:0] tripMv;
  logic        battEdge;
  logic        ccaFire;

  function automatic logic wrHit(input rif_wr_s w, input logic [9:0] a);
    wrHit = w.wrEn && (w.addr == a);
  endfunction

  // ----------------------------------------------------------------
  // battery monitor
  // ----------------------------------------------------------------
  assign tripMv = `RIF_TRIP_BASE_MV
                + 12'(`RIF_TRIP_STEP_MV * {7'h00, battTrip_r[4:0]});

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      railSync1_r <= `RIF_RAIL_SYNC_RESET;
      railSync2_r <= `RIF_RAIL_SYNC_RESET;
    end
    else
    begin
      railSync1_r <= batterySupplyRail;
      railSync2_r <= railSync1_r;
    end
  end

  // a sampled multi-bit code may tear; level compare is re-evaluated
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      battLow_r     <= 1'b0;
      battLowPrev_r <= 1'b0;
    end
    else
    begin
      battLow_r     <= railSync2_r < tripMv;
      battLowPrev_r <= battLow_r;
    end
  end
  assign battEdge = battLow_r && !battLowPrev_r;

  // ----------------------------------------------------------------
  // cca completion waits for valid result
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ccaPending_r <= 1'b0;
      ccaResult_r  <= 1'b0;
    end
    else
    begin
      if (ccaFire)
        ccaPending_r <= 1'b0;
      else if (pktEv.ccaComplete)
        ccaPending_r <= 1'b1;
      if (ccaResultValid)
        ccaResult_r <= ccaResultIn;
    end
  end
  assign ccaFire = (pktEv.ccaComplete || ccaPending_r)
                 && ccaResultValid;

  // ----------------------------------------------------------------
  // flags: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  assign sysSet = {2'b00, sysEv.battAlert || battEdge, sysEv.powerOnReset,
                   sysEv.controllerAcceptsCommandEvent, sysEv.timerTimeout,
                   sysEv.chipReady, 1'b0};
  assign pktSet = {3'b000, pktEv.txPktSent, pktEv.rxPktStored,
                   pktEv.txDelimSent, pktEv.rxDelimSeen, ccaFire};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      sysFlags_r <= `RIF_FLAGS_RESET;
    else if (wrHit(regWr, `RIF_ADDR_SYS_FLAGS))
      sysFlags_r <= ((sysFlags_r & ~regWr.wdata) | sysSet)
                    & `RIF_SYS_MASK;
    else
      sysFlags_r <= (sysFlags_r | sysSet) & `RIF_SYS_MASK;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pktFlags_r <= `RIF_FLAGS_RESET;
    else if (wrHit(regWr, `RIF_ADDR_PKT_FLAGS))
      pktFlags_r <= ((pktFlags_r & ~regWr.wdata) | pktSet)
                    & `RIF_PKT_MASK;
    else
      pktFlags_r <= (pktFlags_r | pktSet) & `RIF_PKT_MASK;
  end

  // ----------------------------------------------------------------
  // enable and threshold registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sysEn1_r   <= `RIF_SYS_EN_RESET;
      pktEn1_r   <= `RIF_PKT_EN_RESET;
      sysEn2_r   <= `RIF_SYS_EN_RESET;
      pktEn2_r   <= `RIF_PKT_EN_RESET;
      battTrip_r <= `RIF_TRIP_RESET;
    end
    else
    begin
      if (wrHit(regWr, `RIF_ADDR_SYS_EN1))
        sysEn1_r <= regWr.wdata & `RIF_SYS_MASK;
      if (wrHit(regWr, `RIF_ADDR_PKT_EN1))
        pktEn1_r <= regWr.wdata & `RIF_PKT_MASK;
      if (wrHit(regWr, `RIF_ADDR_SYS_EN2))
        sysEn2_r <= regWr.wdata & `RIF_SYS_MASK;
      if (wrHit(regWr, `RIF_ADDR_PKT_EN2))
        pktEn2_r <= regWr.wdata & `RIF_PKT_MASK;
      if (wrHit(regWr, `RIF_ADDR_BATT_TRIP))
        battTrip_r <= regWr.wdata & `RIF_TRIP_MASK;
    end
  end

  // ----------------------------------------------------------------
  // interrupt outputs and readback
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irqOut1_r <= 1'b0;
      irqOut2_r <= 1'b0;
    end
    else
    begin
      irqOut1_r <= |(sysFlags_r & sysEn1_r) || |(pktFlags_r & pktEn1_r);
      irqOut2_r <= |(sysFlags_r & sysEn2_r)
                || |(pktFlags_r & pktEn2_r);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdData_r <= 8'h00;
    else if (rdAddr == `RIF_ADDR_SYS_EN1)
      rdData_r <= sysEn1_r;
    else if (rdAddr == `RIF_ADDR_PKT_EN1)
      rdData_r <= pktEn1_r;
    else if (rdAddr == `RIF_ADDR_SYS_EN2)
      rdData_r <= sysEn2_r;
    else if (rdAddr == `RIF_ADDR_PKT_EN2)
      rdData_r <= pktEn2_r;
    else if (rdAddr == `RIF_ADDR_SYS_FLAGS)
      rdData_r <= sysFlags_r;
    else if (rdAddr == `RIF_ADDR_PKT_FLAGS)
      rdData_r <= pktFlags_r;
    else if (rdAddr == `RIF_ADDR_BATT_TRIP)
      rdData_r <= battTrip_r;
    else
      rdData_r <= 8'h00;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sys_flag_set_a: assert property (@(posedge clk) disable iff (reset)
    sysEv.timerTimeout |=> sysFlags_r[2])
    else $error("timer event not latched");
  pkt_flag_set_a: assert property (@(posedge clk) disable iff (reset)
    pktEv.txPktSent |=> pktFlags_r[4])
    else $error("tx done not latched");
  cca_needs_valid_a: assert property (@(posedge clk) disable iff (reset)
    $rose(pktFlags_r[0]) |-> $past(ccaResultValid))
    else $error("cca flag rose without valid result");
  batt_alert_a: assert property (@(posedge clk) disable iff (reset)
    battEdge |=> sysFlags_r[`RIF_BIT_BATT])
    else $error("battery low not flagged");
  batt_cmp_a: assert property (@(posedge clk) disable iff (reset)
    (railSync2_r < tripMv) |=> battLow_r)
    else $error("battery compare wrong");
  en_reset_a: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |-> sysEn2_r == `RIF_SYS_EN_RESET)
    else $error("enable reset value wrong");
  irq2_on_a: assert property (@(posedge clk) disable iff (reset)
    (|(pktFlags_r & pktEn2_r)) |=> irqOut2_r)
    else $error("irq2 not raised");
  irq2_off_a: assert property (@(posedge clk) disable iff (reset)
    !(|(sysFlags_r & sysEn2_r)) && !(|(pktFlags_r & pktEn2_r))
    |=> !irqOut2_r)
    else $error("irq2 raised without cause");
  clear_w1c_a: assert property (@(posedge clk) disable iff (reset)
    wrHit(regWr, `RIF_ADDR_PKT_FLAGS) && regWr.wdata[4] && !pktEv.txPktSent
    |=> !pktFlags_r[4])
    else $error("flag not cleared");
  irq2_cov_c: cover property (@(posedge clk) $rose(irqOut2_r));
  batt_cov_c: cover property (@(posedge clk) battEdge);
  cca_wait_c: cover property (@(posedge clk)
    ccaPending_r && ccaResultValid);
endmodule

// ==== rif_consts.svh ====
// Purpose: offsets, field positions, reset values of the radio irq block
// Assumes: 10-bit register address, 8-bit data
// Notes:   included by the top module
`ifndef RIF_CONSTS_SVH
`define RIF_CONSTS_SVH
`define RIF_ADDR_SYS_EN1    10'h3c7
`define RIF_ADDR_PKT_EN1    10'h3c8
`define RIF_ADDR_SYS_EN2    10'h3c9
`define RIF_ADDR_PKT_EN2    10'h3ca
`define RIF_ADDR_SYS_FLAGS  10'h3cb
`define RIF_ADDR_PKT_FLAGS  10'h3cc
`define RIF_ADDR_BATT_TRIP  10'h3e6
`define RIF_SYS_EN_RESET    8'h02
`define RIF_PKT_EN_RESET    8'h00
`define RIF_FLAGS_RESET     8'h00
`define RIF_TRIP_RESET      8'h00
// rail reads full scale until the first real sample: no alert at reset
`define RIF_RAIL_SYNC_RESET 12'hfff
`define RIF_SYS_MASK        8'h3e
`define RIF_PKT_MASK        8'h1f
`define RIF_TRIP_MASK       8'h1f
`define RIF_BIT_BATT        5
`define RIF_BIT_CCA         0
// trip level in millivolts: base plus step times code
`define RIF_TRIP_BASE_MV    12'd1700
`define RIF_TRIP_STEP_MV    12'd62
`endif

// ==== rif_pkg.sv ====
// Purpose: types of the radio irq block
// Assumes: rif_consts.svh holds the numbers
// Notes:   event bundles travel as packed structs
package rif_pkg;
  typedef struct packed {
    logic battAlert;
    logic powerOnReset;
    logic controllerAcceptsCommandEvent;
    logic timerTimeout;
    logic chipReady;
  } rif_sys_ev_s;
  typedef struct packed {
    logic txPktSent;
    logic rxPktStored;
    logic txDelimSent;
    logic rxDelimSeen;
    logic ccaComplete;
  } rif_pkt_ev_s;
  typedef struct packed {
    logic       wrEn;
    logic [9:0] addr;
    logic [7:0] wdata;
  } rif_wr_s;
endpackage

// ==== rif_evt_model.sv ====
// Purpose: radio core stand-in driving events, cca result, supply rail
// Assumes: events are one-cycle pulses launched at the falling edge
// Notes:   rail and cca lines hold until the bench changes them
`timescale 1ns/1ps
module rif_evt_model
(
  // clock
  input  wire logic            clk,
  // event and analog outputs
  output rif_pkg::rif_sys_ev_s sysEv,
  output rif_pkg::rif_pkt_ev_s pktEv,
  output logic                 ccaValid,
  output logic                 ccaBit,
  output logic [11:0]          rail
);
  import rif_pkg::*;
  initial
  begin
    sysEv = '0;
    pktEv = '0;
    ccaValid = 1'b0;
    ccaBit = 1'b0;
    rail = 12'hbb8;
  end
  // level lines change at the falling edge
  task automatic set_cca(input logic v, input logic b);
    @(negedge clk);
    ccaValid = v;
    ccaBit = b;
  endtask
  task automatic set_rail(input logic [11:0] r);
    @(negedge clk);
    rail = r;
  endtask
  // one-cycle event pulse
  task automatic pulse(input logic [4:0] s, input logic [4:0] p);
    @(negedge clk);
    sysEv = s;
    pktEv = p;
    @(negedge clk);
    sysEv = '0;
    pktEv = '0;
  endtask
endmodule

// ==== tb_top.sv ====
// Purpose: register-level bench of the radio irq flag block
// Assumes: inputs change at the falling edge
// Notes:   reads return one edge after the address is set
`timescale 1ns/1ps
module tb_top;
  import rif_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  rif_wr_s regWr = '0;
  logic [9:0] rdAddr = '0;
  logic [7:0] rdData_r;
  rif_sys_ev_s sysEv;
  rif_pkt_ev_s pktEv;
  logic ccaValid, ccaBit, irqOut1_r, irqOut2_r, ccaResult_r;
  logic [11:0] rail;
  int nFail = 0;
  int checkCount = 0;
  int cyc = 0;
  logic [9:0] addrs [7] = '{10'h3c7, 10'h3c8, 10'h3c9, 10'h3ca,
                            10'h3cb, 10'h3cc, 10'h3e6};
  logic [7:0] rstv [7] = '{8'h02, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  always #12.5 clk = ~clk;
  rif_evt_model ev (.clk(clk), .sysEv(sysEv), .pktEv(pktEv),
    .ccaValid(ccaValid), .ccaBit(ccaBit), .rail(rail));
  rif_irq_flags dut (.clk(clk), .reset(reset), .regWr(regWr),
    .rdAddr(rdAddr), .rdData_r(rdData_r), .sysEv(sysEv), .pktEv(pktEv),
    .ccaResultValid(ccaValid), .batterySupplyRail(rail),
    .irqOut1_r(irqOut1_r), .irqOut2_r(irqOut2_r),
    .ccaResult_r(ccaResult_r), .ccaResultIn(ccaBit));
  task automatic report_and_stop();
    if (nFail == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      nFail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    regWr = '{1'b1, a, d};
    @(negedge clk);
    regWr.wrEn = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(negedge clk);
    rdAddr = a;
    @(negedge clk);
    chk(rdData_r, exp);
  endtask
  // cycle ceiling against hangs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      nFail++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 7; i++) rd(addrs[i], rstv[i]);
    rd(10'h3c6, 8'h00);
    wr(10'h3ca, 8'hff);
    rd(10'h3ca, 8'h1f);
    wr(10'h3c9, 8'hff);
    rd(10'h3c9, 8'h3e);
    wr(10'h3c8, 8'h14);
    rd(10'h3c8, 8'h14);
    for (int i = 1; i < 5; i++)
    begin
      ev.pulse(5'h00, 5'h01 << i);
      rd(10'h3cc, 8'h01 << i);
      chk(irqOut2_r, 8'h01);
      chk(irqOut1_r, (i == 2 || i == 4) ? 8'h01 : 8'h00);
      wr(10'h3cc, 8'h01 << i);
      rd(10'h3cc, 8'h00);
      chk(irqOut2_r, 8'h00);
    end
    for (int i = 0; i < 4; i++)
    begin
      ev.pulse(5'h01 << i, 5'h00);
      rd(10'h3cb, 8'h02 << i);
      chk(irqOut2_r, 8'h01);
      chk(irqOut1_r, (i == 0) ? 8'h01 : 8'h00);
      wr(10'h3cb, 8'h02 << i);
      rd(10'h3cb, 8'h00);
    end
    ev.pulse(5'h00, 5'h01);
    rd(10'h3cc, 8'h00);
    ev.set_cca(1'b1, 1'b1);
    repeat (2) @(negedge clk);
    rd(10'h3cc, 8'h01);
    chk(ccaResult_r, 8'h01);
    wr(10'h3cc, 8'h01);
    rd(10'h3cc, 8'h00);
    ev.set_cca(1'b1, 1'b0);
    ev.pulse(5'h00, 5'h01);
    rd(10'h3cc, 8'h01);
    chk(ccaResult_r, 8'h00);
    wr(10'h3cc, 8'h01);
    ev.set_cca(1'b0, 1'b0);
    rd(10'h3cc, 8'h00);
    wr(10'h3e6, 8'hff);
    rd(10'h3e6, 8'h1f);
    repeat (4) @(negedge clk);
    rd(10'h3cb, 8'h20);
    chk(irqOut2_r, 8'h01);
    wr(10'h3e6, 8'h05);
    repeat (4) @(negedge clk);
    wr(10'h3cb, 8'h20);
    rd(10'h3cb, 8'h00);
    ev.set_rail(12'd2011);
    repeat (8) @(negedge clk);
    rd(10'h3cb, 8'h00);
    chk(irqOut2_r, 8'h00);
    ev.set_rail(12'd2009);
    for (int k = 0; k < 12 && irqOut2_r !== 1'b1; k++) @(negedge clk);
    rd(10'h3cb, 8'h20);
    chk(irqOut2_r, 8'h01);
    report_and_stop();
  end
endmodule
